/* common/rwc_defs.svh */
`ifndef RWC_DEFS_SVH
`define RWC_DEFS_SVH

// Clock rates
`define RWC_PCLK_HZ          50000000
`define RWC_WDT_OSC_HZ       128000

// Watchdog period range, the base count is derived from the shortest period
`define RWC_WDT_MIN_MS       16
`define RWC_WDT_MAX_MS       8000
`define RWC_WDT_BASE_TICKS   (`RWC_WDT_OSC_HZ * `RWC_WDT_MIN_MS / 1000)
`define RWC_WDT_CNT_W        21
`define RWC_WDP_MAX          4'h9

// Timed change window, start-up delay counter and disabled brown-out level code
`define RWC_WIN_CYCLES       3'h4
`define RWC_DLY_W            24
`define RWC_BOD_DISABLED     3'h7

// APB byte addresses
`define RWC_ADDR_W           12
`define RWC_ADDR_CAUSE       12'h054
`define RWC_ADDR_WDCS        12'h060

// Watchdog control and status field positions
`define RWC_WDCS_FLAG        7
`define RWC_WDCS_IE          6
`define RWC_WDCS_P3          5
`define RWC_WDCS_CE          4
`define RWC_WDCS_RE          3
`define RWC_WDCS_PLO         2:0

// Reset values
`define RWC_WDP_RESET        4'h0
`define RWC_CAUSE_RESET      5'h00
`define RWC_PIN_SYNC_RESET   5'h02

`endif

/* common/rwc_pkg.sv */
package rwc_pkg;

  // Reset sequencer, one-hot
  typedef enum logic [2:0] {
    SEQ_HOLD  = 3'b001,
    SEQ_DELAY = 3'b010,
    SEQ_RUN   = 3'b100
  } seq_state_t;

  // Fuse straps, a one means programmed
  typedef struct packed {
    logic       watch_always_on_fuse;
    logic       pin_reset_disable_fuse;
    logic [2:0] brownout_level_fuse;
    logic [1:0] startup_time_fuse;
    logic [3:0] clock_source_fuse;
  } fuses_t;

  // Sticky reset cause flags, register bits 4:0
  typedef struct packed {
    logic jtag;
    logic watch;
    logic brownout;
    logic external;
    logic power_on;
  } reset_cause_t;

endpackage

/* rtl/reset_and_watchdog_control.sv */
`timescale 1ns/100ps

`include "rwc_defs.svh"

// Two-stage synchroniser; the first stage feeds only the second
module rwc_sync #(
  parameter int       W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         en,
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else if (en) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

module reset_and_watchdog_control #(
  parameter int unsigned STARTUP_BASE_CYCLES = 1024
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     ce,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`RWC_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output      logic [31:0]              prdata,
  output      logic                     pready,
  output      logic                     pslverr,
  input  wire rwc_pkg::fuses_t          fuses,
  input  wire logic                     power_ok,
  input  wire logic                     reset_pin_n,
  input  wire logic                     brownout_low,
  input  wire logic                     jtag_reset_hold,
  input  wire logic                     watch_osc_clk,
  input  wire logic                     watch_restart,
  input  wire logic                     watch_vector_ack,
  input  wire logic                     comparator_bandgap_select,
  input  wire logic                     converter_enable,
  output      logic                     io_reset_n,
  output      logic                     core_reset_n,
  output      logic                     watch_irq,
  output      logic                     bandgap_enable
);

  rwc_pkg::seq_state_t   seq_state;
  rwc_pkg::fuses_t       fuse_s;
  rwc_pkg::reset_cause_t cause;
  logic [4:0]                 pin_s;
  logic                       src_async;
  logic                       hold_n;
  logic                       bod_en;
  logic                       por_src;
  logic                       ext_src;
  logic                       bor_src;
  logic                       jtag_src;
  logic                       src_sync;
  logic [`RWC_DLY_W-1:0]      dly_cnt;
  logic [`RWC_DLY_W-1:0]      dly_limit;
  logic [2:0]                 dly_shift;
  logic                       osc_d;
  logic                       osc_tick;
  logic [`RWC_WDT_CNT_W-1:0]  wdt_cnt;
  logic [`RWC_WDT_CNT_W-1:0]  wdt_limit;
  logic [3:0]                 watch_prescale_select;
  logic [3:0]                 wdp_eff;
  logic                       watch_reset_enable;
  logic                       watch_irq_enable;
  logic                       watch_irq_flag;
  logic                       re_eff;
  logic                       ie_eff;
  logic                       running;
  logic                       timeout;
  logic                       irq_set;
  logic                       wdt_rst;
  logic                       wdt_pulse;
  logic [2:0]                 win_cnt;
  logic                       win_open;
  logic                       wr_en;
  logic                       wr_wdcs;
  logic                       wr_cause;
  logic [7:0]                 wd;
  logic                       open_seq;
  logic                       apply_seq;

  // Fuses and pins come from outside the clock domain
  rwc_sync #(
    .W       ($bits(rwc_pkg::fuses_t)),
    .RST_VAL ('0)
  ) u_fuse_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .en    (ce),
    .d     (fuses),
    .q     (fuse_s)
  );

  rwc_sync #(
    .W       (5),
    .RST_VAL (`RWC_PIN_SYNC_RESET)
  ) u_pin_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .en    (ce),
    .d     ({watch_osc_clk, jtag_reset_hold, brownout_low, reset_pin_n, power_ok}),
    .q     (pin_s)
  );

  // Raw source combination; acts with no clock running, so it uses raw pins
  assign src_async = ~power_ok
                   | (~reset_pin_n & ~fuses.pin_reset_disable_fuse)
                   | ((fuses.brownout_level_fuse != `RWC_BOD_DISABLED)
                      & brownout_low)
                   | jtag_reset_hold;
  assign hold_n    = presetn & ~src_async;

  // Synchronised view of the same sources, for release and cause flags
  assign bod_en   = (fuse_s.brownout_level_fuse != `RWC_BOD_DISABLED);
  assign por_src  = ~pin_s[0];
  assign ext_src  = ~pin_s[1] & ~fuse_s.pin_reset_disable_fuse;
  assign bor_src  = bod_en & pin_s[2];
  assign jtag_src = pin_s[3];
  assign src_sync = por_src | ext_src | bor_src | jtag_src;

  // Delay length from start-up and clock-source fuses
  assign dly_shift = {1'b0, fuse_s.startup_time_fuse} + {2'b00, fuse_s.clock_source_fuse[0]};
  assign dly_limit = `RWC_DLY_W'(STARTUP_BASE_CYCLES) << dly_shift;

  // Reset sequencer; release waits for the synchronised sources so exit is clean
  always_ff @(posedge pclk or negedge hold_n) begin
    if (!hold_n) begin
      seq_state <= rwc_pkg::SEQ_HOLD;
      dly_cnt   <= '0;
    end else if (ce) begin
      case (seq_state)
        rwc_pkg::SEQ_HOLD: begin
          dly_cnt <= '0;
          if (!src_sync && !wdt_pulse) begin
            seq_state <= rwc_pkg::SEQ_DELAY;
          end
        end
        rwc_pkg::SEQ_DELAY: begin
          if (src_sync || wdt_pulse) begin
            seq_state <= rwc_pkg::SEQ_HOLD;
          end else if (dly_cnt >= dly_limit - `RWC_DLY_W'(1)) begin
            seq_state <= rwc_pkg::SEQ_RUN;
          end else begin
            dly_cnt <= dly_cnt + `RWC_DLY_W'(1);
          end
        end
        rwc_pkg::SEQ_RUN: begin
          if (src_sync || wdt_pulse) begin
            seq_state <= rwc_pkg::SEQ_HOLD;
          end
        end
        default: begin
          seq_state <= rwc_pkg::SEQ_HOLD;
        end
      endcase
    end
  end

  assign running = (seq_state == rwc_pkg::SEQ_RUN);

  // Port and core resets drop at once with any pin source, one clock after the watchdog pulse, release after the delay
  always_ff @(posedge pclk or negedge hold_n) begin
    if (!hold_n) begin
      io_reset_n   <= 1'b0;
      core_reset_n <= 1'b0;
    end else if (ce) begin
      io_reset_n   <= running & ~wdt_pulse & ~src_sync;
      core_reset_n <= running & ~wdt_pulse & ~src_sync;
    end
  end

  // Watchdog oscillator edge detect on the synchronised copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_d <= 1'b0;
    end else if (ce) begin
      osc_d <= pin_s[4];
    end
  end

  assign osc_tick = pin_s[4] & ~osc_d;

  // Mode decode; the fuse overrides both enable bits
  assign re_eff  = fuse_s.watch_always_on_fuse | watch_reset_enable;
  assign ie_eff  = ~fuse_s.watch_always_on_fuse & watch_irq_enable;
  assign wdp_eff = (watch_prescale_select > `RWC_WDP_MAX) ? `RWC_WDP_MAX : watch_prescale_select;
  assign wdt_limit = `RWC_WDT_CNT_W'(`RWC_WDT_BASE_TICKS) << wdp_eff;

  // Reserved prescaler codes are clamped to the longest period
  assign timeout = running & (re_eff | ie_eff) & osc_tick
                 & (wdt_cnt >= wdt_limit - `RWC_WDT_CNT_W'(1));
  // Combined mode: a pending flag means the switch to reset mode has happened
  assign irq_set = timeout & ie_eff & (~re_eff | ~watch_irq_flag);
  assign wdt_rst = timeout & re_eff & (~ie_eff | watch_irq_flag);

  // Watchdog counter; no sleep input gates it, so sleep cannot stop it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_cnt <= '0;
    end else if (ce) begin
      if (!running || watch_restart || timeout) begin
        wdt_cnt <= '0;
      end else if (osc_tick && (re_eff || ie_eff)) begin
        wdt_cnt <= wdt_cnt + `RWC_WDT_CNT_W'(1);
      end
    end
  end

  // One-cycle system reset pulse on expiry in reset mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_pulse <= 1'b0;
    end else if (ce) begin
      wdt_pulse <= wdt_rst;
    end
  end

  // APB decode; writes take effect on the access edge only
  assign wr_en    = psel & penable & pready & pwrite & pstrb[0];
  assign wr_wdcs  = wr_en & (paddr == `RWC_ADDR_WDCS);
  assign wr_cause = wr_en & (paddr == `RWC_ADDR_CAUSE);
  assign wd       = pwdata[7:0];
  assign win_open = (win_cnt != 3'h0);
  assign open_seq  = wr_wdcs & wd[`RWC_WDCS_CE] & wd[`RWC_WDCS_RE];
  assign apply_seq = wr_wdcs & ~wd[`RWC_WDCS_CE] & win_open;

  // Change window counts down four cycles from the opening write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt <= 3'h0;
    end else if (ce) begin
      if (!running || apply_seq) begin
        win_cnt <= 3'h0;
      end else if (open_seq) begin
        win_cnt <= `RWC_WIN_CYCLES;
      end else if (win_open) begin
        win_cnt <= win_cnt - 3'h1;
      end
    end
  end

  // Protected settings; setting the reset enable needs no window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watch_reset_enable <= 1'b0;
      watch_prescale_select <= `RWC_WDP_RESET;
    end else if (ce) begin
      if (!running) begin
        watch_reset_enable <= 1'b0;
        watch_prescale_select <= `RWC_WDP_RESET;
      end else if (apply_seq) begin
        watch_reset_enable <= wd[`RWC_WDCS_RE];
        watch_prescale_select <= {wd[`RWC_WDCS_P3], wd[`RWC_WDCS_PLO]};
      end else if (wr_wdcs && wd[`RWC_WDCS_RE]) begin
        watch_reset_enable <= 1'b1;
      end
    end
  end

  // Interrupt enable is unprotected; the vector drops it in combined mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watch_irq_enable <= 1'b0;
    end else if (ce) begin
      if (!running) begin
        watch_irq_enable <= 1'b0;
      end else if (watch_vector_ack && re_eff) begin
        watch_irq_enable <= 1'b0;
      end else if (wr_wdcs) begin
        watch_irq_enable <= wd[`RWC_WDCS_IE];
      end
    end
  end

  // Interrupt flag; a new expiry wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watch_irq_flag <= 1'b0;
    end else if (ce) begin
      if (irq_set) begin
        watch_irq_flag <= 1'b1;
      end else if (!running || watch_vector_ack || (wr_wdcs && wd[`RWC_WDCS_FLAG])) begin
        watch_irq_flag <= 1'b0;
      end
    end
  end

  // Cause flags survive every reset except the bus reset; a power-on source also clears the other four
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause <= `RWC_CAUSE_RESET;
    end else if (ce) begin
      cause.power_on <= por_src | (cause.power_on & ~(wr_cause & ~wd[0]));
      cause.external <= ext_src | (cause.external & ~(wr_cause & ~wd[1]) & ~por_src);
      cause.brownout <= bor_src | (cause.brownout & ~(wr_cause & ~wd[2]) & ~por_src);
      cause.watch    <= wdt_pulse | (cause.watch & ~(wr_cause & ~wd[3]) & ~por_src);
      cause.jtag     <= jtag_src | (cause.jtag & ~(wr_cause & ~wd[4]) & ~por_src);
    end
  end

  // Zero-wait slave: ready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & (paddr != `RWC_ADDR_WDCS) & (paddr != `RWC_ADDR_CAUSE);
      if (psel && !penable && !pwrite && paddr == `RWC_ADDR_WDCS) begin
        prdata <= {24'h00_0000, watch_irq_flag, ie_eff, watch_prescale_select[3], win_open, re_eff, watch_prescale_select[2:0]};
      end else if (psel && !penable && !pwrite && paddr == `RWC_ADDR_CAUSE) begin
        prdata <= {27'h000_0000, cause};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Request and reference outputs, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watch_irq      <= 1'b0;
      bandgap_enable <= 1'b0;
    end else if (ce) begin
      watch_irq      <= watch_irq_flag & ie_eff;
      bandgap_enable <= bod_en | comparator_bandgap_select | converter_enable;
    end
  end

  // Software keeps interrupts masked around the opening and applying writes

endmodule

/* sim/reset_watch_checker.sv */
`timescale 1ns/100ps

`include "rwc_defs.svh"

// Reset outputs against their raw sources, plus the APB answer
module reset_watch_checker #(
  parameter int unsigned STARTUP_BASE_CYCLES = 1024
) (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic [`RWC_ADDR_W-1:0] paddr,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire rwc_pkg::fuses_t        fuses,
  input wire logic                   power_ok,
  input wire logic                   reset_pin_n,
  input wire logic                   brownout_low,
  input wire logic                   jtag_reset_hold,
  input wire logic                   comparator_bandgap_select,
  input wire logic                   converter_enable,
  input wire logic                   io_reset_n,
  input wire logic                   core_reset_n,
  input wire logic                   watch_irq,
  input wire logic                   bandgap_enable
);
  logic       bod_on;
  logic       src_clear;
  logic [1:0] up;
  logic [1:0] bod_d;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Source state as seen at the pins
  assign bod_on = fuses.brownout_level_fuse != `RWC_BOD_DISABLED;
  assign src_clear = power_ok && (reset_pin_n || fuses.pin_reset_disable_fuse)
                     && !jtag_reset_hold && !(brownout_low && bod_on);

  // Edges since release; fuse syncs need three before bandgap is judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up <= 2'h0;
    end else if (up != 2'h3) begin
      up <= up + 2'h1;
    end
  end

  // Fuses reach the design through two flops; mirror that lag so a fuse change is judged fairly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bod_d <= 2'h0;
    end else begin
      bod_d <= {bod_d[0], bod_on};
    end
  end

  a_ports_follow_core: assert property ((io_reset_n == core_reset_n)
    && (src_clear || !io_reset_n))
    else $error("port reset wrong or differs from core reset");
  a_power_low_holds: assert property (!power_ok |-> !core_reset_n)
    else $error("reset high with supply low");
  a_pin_low_resets: assert property (!reset_pin_n && !fuses.pin_reset_disable_fuse
    |-> !io_reset_n)
    else $error("pin low did not reset ports");
  a_brownout_resets: assert property (brownout_low && bod_on |-> !core_reset_n)
    else $error("brown-out did not reset");
  a_test_hold_resets: assert property (jtag_reset_hold |-> !core_reset_n)
    else $error("test-port hold did not reset");
  a_release_waits_delay: assert property ($rose(core_reset_n) |-> $past(src_clear, 6))
    else $error("reset released without delay");
  a_reset_stretched: assert property ($fell(core_reset_n) |-> !core_reset_n [*5])
    else $error("reset shorter than delay");
  a_bandgap_demand: assert property (up == 2'h3 |->
    bandgap_enable == $past(bod_d[1] || comparator_bandgap_select || converter_enable))
    else $error("bandgap enable wrong");
  a_irq_off_in_reset: assert property (!core_reset_n [*3] |-> !watch_irq)
    else $error("irq high during reset");
  a_apb_answers: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");
  a_apb_unmapped: assert property (pready |->
    pslverr == !(paddr == `RWC_ADDR_CAUSE || paddr == `RWC_ADDR_WDCS))
    else $error("slave error wrong for address");
endmodule

bind reset_and_watchdog_control reset_watch_checker #(
  .STARTUP_BASE_CYCLES(STARTUP_BASE_CYCLES)
) i_reset_watch_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .fuses(fuses), .power_ok(power_ok),
  .reset_pin_n(reset_pin_n), .brownout_low(brownout_low), .jtag_reset_hold(jtag_reset_hold),
  .comparator_bandgap_select(comparator_bandgap_select), .converter_enable(converter_enable),
  .io_reset_n(io_reset_n), .core_reset_n(core_reset_n), .watch_irq(watch_irq),
  .bandgap_enable(bandgap_enable)
);

/* sim/watch_osc_model.sv */
`timescale 1ns/100ps

// Watchdog oscillator on its own time base; its edges drift against pclk
module watch_osc_model #(
  parameter real HALF_NS = 62.5
) (
  output logic watch_osc_clk
);
  // Free running, sped up so a timeout fits a short run
  initial begin
    watch_osc_clk = 1'b0;
    forever begin
      #(HALF_NS) watch_osc_clk = ~watch_osc_clk;
    end
  end
endmodule

/* sim/reset_and_watchdog_control_bench.sv */
`timescale 1ns/100ps

`include "rwc_defs.svh"

module reset_and_watchdog_control_bench;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata;
  rwc_pkg::fuses_t fuses;
  logic            power_ok, reset_pin_n, brownout_low, jtag_reset_hold, watch_osc_clk;
  logic            watch_restart, watch_vector_ack, cbs, conv;
  logic            io_reset_n, core_reset_n, watch_irq, bandgap_enable, err;
  int              failures, n_checks;

  reset_and_watchdog_control #(.STARTUP_BASE_CYCLES(4)) i_reset_and_watchdog_control (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fuses(fuses), .power_ok(power_ok),
    .reset_pin_n(reset_pin_n), .brownout_low(brownout_low),
    .jtag_reset_hold(jtag_reset_hold), .watch_osc_clk(watch_osc_clk),
    .watch_restart(watch_restart), .watch_vector_ack(watch_vector_ack),
    .comparator_bandgap_select(cbs), .converter_enable(conv), .io_reset_n(io_reset_n),
    .core_reset_n(core_reset_n), .watch_irq(watch_irq), .bandgap_enable(bandgap_enable)
  );

  watch_osc_model i_watch_osc_model (.watch_osc_clk(watch_osc_clk));

  // 50 MHz
  always #10 pclk = ~pclk;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_up();
    failures++;
    $display("wrong value at %0t: wait ran out", $time);
    tally_and_finish();
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) give_up();
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 8'h00, r);
    check(r, exp);
  endtask

  // Bounded wait on the irq or on the core reset reaching a level
  task automatic wait_sig(input bit irq, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((irq ? watch_irq : core_reset_n) !== lvl) begin
      @(posedge pclk);
      n++;
      if (n > lim) give_up();
    end
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    fuses = '0;
    fuses.brownout_level_fuse = `RWC_BOD_DISABLED;
    {power_ok, brownout_low, jtag_reset_hold, watch_restart, watch_vector_ack} = '0;
    {cbs, conv, failures, n_checks} = '0;
    reset_pin_n = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    power_ok <= 1'b1;
    wait_sig(0, 1'b1, 200);
    rdc(`RWC_ADDR_CAUSE, 32'h01);
    rdc(`RWC_ADDR_WDCS, 32'h00);
    rdc(12'h058, 32'h00);
    check(err, 1'b1);
    wr(`RWC_ADDR_CAUSE, 8'h00);
    rdc(`RWC_ADDR_CAUSE, 32'h00);
    $display("test power-on done");
    // Pin reset then test-port hold, each leaving only its own cause
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      if (i == 0) reset_pin_n <= 1'b0;
      else jtag_reset_hold <= 1'b1;
      #1 check(io_reset_n, 1'b0);
      repeat (4) @(posedge pclk);
      reset_pin_n <= 1'b1;
      jtag_reset_hold <= 1'b0;
      wait_sig(0, 1'b1, 200);
      rdc(`RWC_ADDR_CAUSE, i == 0 ? 32'h02 : 32'h10);
      wr(`RWC_ADDR_CAUSE, 8'h00);
    end
    // Disabled detector must not reset; bandgap follows its users
    brownout_low <= 1'b1;
    conv <= 1'b1;
    repeat (3) @(posedge pclk);
    check(core_reset_n, 1'b1);
    check(bandgap_enable, 1'b1);
    {brownout_low, conv, cbs} <= 3'b001;
    repeat (3) @(posedge pclk);
    check(bandgap_enable, 1'b1);
    cbs <= 1'b0;
    repeat (3) @(posedge pclk);
    check(bandgap_enable, 1'b0);
    // Enabled detector resets at once and lets go only after the delay
    fuses.brownout_level_fuse <= 3'h0;
    repeat (4) @(posedge pclk);
    check(bandgap_enable, 1'b1);
    brownout_low <= 1'b1;
    #1 check(io_reset_n, 1'b0);
    repeat (4) @(posedge pclk);
    brownout_low <= 1'b0;
    wait_sig(0, 1'b1, 200);
    rdc(`RWC_ADDR_CAUSE, 32'h04);
    wr(`RWC_ADDR_CAUSE, 8'h00);
    fuses.brownout_level_fuse <= `RWC_BOD_DISABLED;
    $display("test sources done");
    // Timed change sequence: refused, accepted, expired; no vector ack in flight
    wr(`RWC_ADDR_WDCS, 8'h08);
    wr(`RWC_ADDR_WDCS, 8'h00);
    rdc(`RWC_ADDR_WDCS, 32'h08);
    wr(`RWC_ADDR_WDCS, 8'h18);
    wr(`RWC_ADDR_WDCS, 8'h01);
    rdc(`RWC_ADDR_WDCS, 32'h01);
    wr(`RWC_ADDR_WDCS, 8'h18);
    repeat (6) @(posedge pclk);
    wr(`RWC_ADDR_WDCS, 8'h01);
    rdc(`RWC_ADDR_WDCS, 32'h09);
    wr(`RWC_ADDR_WDCS, 8'h18);
    wr(`RWC_ADDR_WDCS, 8'h40);
    rdc(`RWC_ADDR_WDCS, 32'h40);
    $display("test timed sequence done");
    // Interrupt mode: restarts hold off expiry, then flag and request
    repeat (2) begin
      repeat (8000) @(posedge pclk);
      watch_restart <= 1'b1;
      @(posedge pclk);
      watch_restart <= 1'b0;
    end
    check(watch_irq, 1'b0);
    wait_sig(1, 1'b1, 20000);
    check(core_reset_n, 1'b1);
    rdc(`RWC_ADDR_WDCS, 32'hc0);
    wr(`RWC_ADDR_WDCS, 8'hc0);
    rdc(`RWC_ADDR_WDCS, 32'h40);
    $display("test interrupt mode done");
    // Combined mode: interrupt, vector, then reset on the next expiry
    wr(`RWC_ADDR_WDCS, 8'h48);
    wait_sig(1, 1'b1, 20000);
    check(core_reset_n, 1'b1);
    @(posedge pclk);
    watch_vector_ack <= 1'b1;
    @(posedge pclk);
    watch_vector_ack <= 1'b0;
    rdc(`RWC_ADDR_WDCS, 32'h08);
    wait_sig(0, 1'b0, 20000);
    wait_sig(0, 1'b1, 200);
    rdc(`RWC_ADDR_CAUSE, 32'h08);
    rdc(`RWC_ADDR_WDCS, 32'h00);
    $display("test combined mode done");
    // Always-on fuse locks reset mode and keeps irq enable low
    fuses.watch_always_on_fuse <= 1'b1;
    repeat (4) @(posedge pclk);
    wr(`RWC_ADDR_WDCS, 8'h40);
    rdc(`RWC_ADDR_WDCS, 32'h08);
    $display("test always-on done");
    tally_and_finish();
  end
endmodule
